/* design/rbs_pkg.sv */
// Constants and carrier types for the reset boot sequencer.
package rbs_pkg;
  localparam logic [23:0] RESET_VEC     = 24'hffff00;
  localparam logic [11:0] PLL_VP_12M    = 12'h2ed;
  localparam logic [1:0]  PLL_VS_12M    = 2'h0;
  localparam logic [9:0]  PLL_VO_12M    = 10'h000;
  localparam logic [10:0] MULT_12M      = 11'h177;
  localparam logic [10:0] MULT_FB_EXT   = 11'h003;
  localparam logic [10:0] MULT_FB_RTC   = 11'h465;
  localparam logic [2:0]  NOR_CS_FIRST  = 3'h2;
  localparam logic [1:0]  NOR_CS_LAST   = 2'h3;
  localparam logic [2:0]  SPI_CS        = 3'h0;
  localparam logic [2:0]  SPI_MODE_A    = 3'h5;
  localparam logic [1:0]  SPI_LAST      = 2'h1;
  localparam logic [9:0]  SPI_KHZ       = 10'h1f4;
  localparam logic [9:0]  I2C_KHZ       = 10'h190;
  localparam logic [6:0]  I2C_ADDR      = 7'h50;
  localparam logic [15:0] BOOT_SIG_DEF  = 16'h0001;
  localparam int          SETTLE_MS     = 200;
  localparam int          CLK_KHZ       = 200000;
  localparam int          PCLK_EMIF     = 0;
  localparam int          PCLK_SPI      = 1;
  localparam int          PCLK_I2C      = 2;
  localparam int          PCLK_UART     = 3;
  localparam int          PCLK_USB      = 4;
  localparam int          NPCLK         = 5;

  typedef enum logic [2:0] {
    PK_NONE, PK_NOR, PK_NAND, PK_SPI, PK_I2C, PK_UART, PK_USB
  } rbs_kind_t;

  typedef struct packed {
    rbs_kind_t   kind;
    logic [2:0]  cs;
    logic        wide16;
    logic [2:0]  bus_mode;
    logic [9:0]  rate_khz;
    logic [6:0]  i2c_addr;
  } rbs_probe_t;

  typedef struct packed {
    logic        pwr;
    logic        bypass;
    logic [11:0] vp;
    logic [1:0]  vs;
    logic        in_div_en;
    logic        out_div2_en;
    logic        out_div_en;
    logic [9:0]  vo;
    logic [10:0] mult;
  } rbs_pll_t;

  typedef struct packed {
    logic cpu;
    logic periph;
    logic memory_port;
    logic hw_accelerator;
    logic misc;
  } rbs_idle_t;
endpackage

/* design/rbs_settle_timer.sv */
// First timer used to hold off the jump for the settling interval.
`timescale 1ns/10ps
module rbs_settle_timer #(
  parameter int unsigned CYC = 40000000
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_start,
  output logic      o_running,
  output logic      o_expired
);
  logic [31:0] cnt_q;
  wire         last = (cnt_q == 32'(CYC - 1));

  // A restart while running begins the full interval again.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q     <= 32'h0;
      o_running <= 1'b0;
      o_expired <= 1'b0;
    end else if (i_start) begin
      cnt_q     <= 32'h0;
      o_running <= 1'b1;
      o_expired <= 1'b0;
    end else if (o_running) begin
      cnt_q     <= cnt_q + 32'h1;
      o_running <= !last;
      o_expired <= last;
    end
  end
endmodule // rbs_settle_timer

/* design/rbs_boot_seq.sv */
// Post-reset boot sequencer: clock setup, boot probing, settle, jump.
// Operation
// - Sequence starts by itself whenever device reset is released.
// - Fetch reset vector 0xffff00 from internal ROM, PLL bypassed.
// - Set clock output to slow slew, then idle peripherals, port, accelerator.
// - Strap low: power PLL, multiply 32.768 kHz by 375 for 12.288 MHz.
// - That setting uses multiplier 749, aux 0, output divide-by-2, divider 0.
// - Strap high: keep PLL bypassed, system clock from reference input.
// - Trim bandgap, disable clock output, apply image config only if present.
// - Probe reads two bytes, compares with signature; mismatch moves on.
// - NOR probe on chip selects two to five with 16-bit accesses.
// - NAND probe on chip selects two to five with 8-bit accesses.
// - SPI EEPROM on select 0 at 500 kHz, bus mode 5 then 6.
// - I2C EEPROM at address 0x50 with 400 kHz clock.
// - Order NOR, NAND, SPI, I2C; first valid signature wins.
// - All fail: PLL to about 36 MHz, multiplier 3 or 1125.
// - Then loop forever over UART and USB checks until reset.
// - After image load completes, start first timer for 200 ms before running code.
// - After settling, jump to the image entry point.
// - All peripheral clocks off at hardware reset.
// - Peripheral clock on only while that peripheral is queried or loading the image.
// - At hand-off all peripheral clocks off, all but processor idled.
`timescale 1ns/10ps
module rbs_boot_seq
  import rbs_pkg::*;
#(
  parameter logic [15:0] BOOT_SIG   = rbs_pkg::BOOT_SIG_DEF,
  parameter int unsigned SETTLE_CYC = rbs_pkg::SETTLE_MS * rbs_pkg::CLK_KHZ
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_clk_sel,
  input  wire logic               i_img_has_cfg,
  input  wire logic               i_cfg_done,
  input  wire logic               i_probe_done,
  input  wire logic [15:0]        i_probe_sig,
  input  wire logic               i_load_done,
  input  wire logic [23:0]        i_entry,
  output logic [23:0]             o_fetch_vec,
  output logic                    o_rom_map,
  output logic                    o_clock_output_pin_slow,
  output logic                    o_clock_output_pin_en,
  output rbs_pkg::rbs_idle_t      o_idle,
  output rbs_pkg::rbs_pll_t       o_pll,
  output logic                    o_trim_apply,
  output logic                    o_cfg_req,
  output logic                    o_probe_req,
  output rbs_pkg::rbs_probe_t     o_probe,
  output logic                    o_load_req,
  output rbs_pkg::rbs_kind_t      o_boot_src,
  output logic [4:0]              o_pclk_en,
  output logic                    o_fallback,
  output logic                    o_timer_run,
  output logic                    o_jump,
  output logic [23:0]             o_entry
);
  import rbs_pkg::*;

  typedef enum logic [4:0] {
    S_VEC, S_SLEW, S_IDLE, S_CLK, S_TRIM, S_CLKOFF, S_CFG,
    S_NOR, S_NAND, S_SPI, S_I2C, S_FALLBK, S_UART, S_USB,
    S_LOAD, S_SETTLE, S_JUMP
  } rbs_state_t;

  rbs_state_t  state_q, state_d;
  logic [1:0]  idx_q, idx_d;
  logic        strap_q;
  rbs_kind_t   src_q, src_d;
  logic        tmr_exp;
  logic        tmr_start_q;

  function automatic logic is_probe(input rbs_state_t s);
    return s inside {S_NOR, S_NAND, S_SPI, S_I2C};
  endfunction

  function automatic rbs_kind_t kind_of(input rbs_state_t s);
    unique case (s)
      S_NOR:   return PK_NOR;
      S_NAND:  return PK_NAND;
      S_SPI:   return PK_SPI;
      S_I2C:   return PK_I2C;
      S_UART:  return PK_UART;
      S_USB:   return PK_USB;
      default: return PK_NONE;
    endcase
  endfunction

  // Clock gate per peripheral; the loading source keeps its clock on.
  function automatic logic [4:0] pclk_for(input rbs_state_t s,
                                          input rbs_kind_t  k);
    logic [4:0] m;
    rbs_kind_t  q;
    m = 5'h00;
    q = (s == S_LOAD) ? k : kind_of(s);
    unique case (q)
      PK_NOR, PK_NAND: m[PCLK_EMIF] = 1'b1;
      PK_SPI:          m[PCLK_SPI]  = 1'b1;
      PK_I2C:          m[PCLK_I2C]  = 1'b1;
      PK_UART:         m[PCLK_UART] = 1'b1;
      PK_USB:          m[PCLK_USB]  = 1'b1;
      PK_NONE:         m = 5'h00;
    endcase
    return m;
  endfunction

  wire take   = o_probe_req && i_probe_done;
  wire sig_ok = (i_probe_sig == BOOT_SIG);
  wire last_i = (state_q inside {S_NOR, S_NAND}) ? (idx_q == NOR_CS_LAST)
              : (state_q == S_SPI) ? (idx_q == SPI_LAST) : 1'b1;
  wire [10:0] fb_mult = strap_q ? MULT_FB_EXT : MULT_FB_RTC;

  always_comb begin
    state_d = state_q;
    idx_d   = idx_q;
    src_d   = src_q;
    unique case (state_q)
      S_VEC:    state_d = S_SLEW;
      S_SLEW:   state_d = S_IDLE;
      S_IDLE:   state_d = S_CLK;
      S_CLK:    state_d = S_TRIM;
      S_TRIM:   state_d = S_CLKOFF;
      S_CLKOFF: state_d = S_CFG;
      S_CFG:    if (!i_img_has_cfg || i_cfg_done) state_d = S_NOR;
      S_NOR, S_NAND, S_SPI, S_I2C: begin
        if (take) begin
          idx_d = idx_q + 2'h1;
          if (sig_ok) begin
            state_d = S_LOAD;
            src_d   = kind_of(state_q);
            idx_d   = 2'h0;
          end else if (last_i) begin
            idx_d   = 2'h0;
            unique case (state_q)
              S_NOR:   state_d = S_NAND;
              S_NAND:  state_d = S_SPI;
              S_SPI:   state_d = S_I2C;
              default: state_d = S_FALLBK;
            endcase
          end
        end
      end
      S_FALLBK: state_d = S_UART;
      S_UART:   state_d = S_USB;
      S_USB:    state_d = S_UART;
      S_LOAD:   if (i_load_done) state_d = S_SETTLE;
      S_SETTLE: if (tmr_exp) state_d = S_JUMP;
      S_JUMP:   state_d = S_JUMP;
    endcase
  end

  // Probe descriptor for the next cycle, built from the next state.
  rbs_probe_t probe_d;
  wire        in_emif = state_d inside {S_NOR, S_NAND};
  assign probe_d.kind     = kind_of(state_d);
  assign probe_d.cs       = in_emif ? NOR_CS_FIRST + 3'(idx_d)
                                    : SPI_CS;
  assign probe_d.wide16   = (state_d == S_NOR);
  assign probe_d.bus_mode = (state_d == S_SPI) ? SPI_MODE_A + 3'(idx_d)
                                               : 3'h0;
  assign probe_d.rate_khz = (state_d == S_SPI) ? SPI_KHZ
                          : (state_d == S_I2C) ? I2C_KHZ : 10'h000;
  assign probe_d.i2c_addr = (state_d == S_I2C) ? I2C_ADDR
                                               : 7'h00;

  // The strap is caught once, on the first clocked state after release.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_q <= 1'b0;
    end else if (state_q == S_VEC) begin
      strap_q <= i_clk_sel;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q     <= S_VEC;
      idx_q       <= 2'h0;
      src_q       <= PK_NONE;
      o_probe_req <= 1'b0;
      o_probe     <= '0;
      o_pclk_en   <= 5'h00;
      o_load_req  <= 1'b0;
      o_cfg_req   <= 1'b0;
      o_fallback  <= 1'b0;
      tmr_start_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      idx_q       <= idx_d;
      src_q       <= src_d;
      o_probe_req <= is_probe(state_d) && !take;
      o_probe     <= probe_d;
      o_pclk_en   <= pclk_for(state_d, src_d);
      o_load_req  <= (state_d == S_LOAD);
      o_cfg_req   <= (state_d == S_CFG) && i_img_has_cfg;
      o_fallback  <= o_fallback || (state_d == S_FALLBK);
      tmr_start_q <= (state_q == S_LOAD) && i_load_done;
    end
  end

  // Clock generator, slew, idle and hand-off outputs.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fetch_vec   <= RESET_VEC;
      o_rom_map     <= 1'b0;
      o_clock_output_pin_slow <= 1'b0;
      o_clock_output_pin_en   <= 1'b1;
      o_idle        <= '0;
      o_pll         <= '0;
      o_trim_apply  <= 1'b0;
      o_jump        <= 1'b0;
      o_entry       <= 24'h000000;
    end else begin
      o_trim_apply <= (state_q == S_TRIM);
      unique case (state_q)
        S_VEC:    o_pll.bypass  <= 1'b1;
        S_SLEW:   o_clock_output_pin_slow <= 1'b1;
        S_IDLE: begin
          o_idle.periph <= 1'b1;
          o_idle.memory_port  <= 1'b1;
          o_idle.hw_accelerator    <= 1'b1;
        end
        S_CLK: begin
          if (!strap_q) begin
            o_pll.pwr         <= 1'b1;
            o_pll.bypass      <= 1'b0;
            o_pll.vp          <= PLL_VP_12M;
            o_pll.vs          <= PLL_VS_12M;
            o_pll.in_div_en   <= 1'b0;
            o_pll.out_div2_en <= 1'b1;
            o_pll.out_div_en  <= 1'b1;
            o_pll.vo          <= PLL_VO_12M;
            o_pll.mult        <= MULT_12M;
          end else begin
            o_pll.bypass      <= 1'b1;
          end
        end
        S_CLKOFF: o_clock_output_pin_en <= 1'b0;
        S_FALLBK: begin
          o_pll.pwr    <= 1'b1;
          o_pll.bypass <= 1'b0;
          o_pll.mult   <= fb_mult;
          o_pll.vp     <= 12'({fb_mult, 1'b0} - 12'h1);
        end
        S_LOAD:   if (i_load_done) o_entry <= i_entry;
        S_SETTLE: if (tmr_exp) begin
          o_jump      <= 1'b1;
          o_idle.misc <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  assign o_boot_src = src_q;

  rbs_settle_timer #(
    .CYC       (SETTLE_CYC)
  ) u_first_timer (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (tmr_start_q),
    .o_running (o_timer_run),
    .o_expired (tmr_exp)
  );

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  boot_start_a: assert property (
    state_q == S_VEC |=> state_q == S_SLEW ##1 state_q == S_IDLE)
    else $error("boot did not start after reset");
  early_bypass_a: assert property (
    state_q inside {S_SLEW, S_IDLE} |-> o_pll.bypass && !o_rom_map
      && o_fetch_vec == RESET_VEC)
    else $error("vector or bypass wrong early in boot");
  slew_idle_a: assert property (
    state_q == S_IDLE |-> o_clock_output_pin_slow ##1 o_idle.hw_accelerator && o_idle.memory_port)
    else $error("slew or idle order wrong");
  pll_rtc_a: assert property (
    state_q == S_CLK && !strap_q |=> o_pll.mult == MULT_12M
      && o_pll.vp == PLL_VP_12M && o_pll.out_div2_en && !o_pll.bypass)
    else $error("pll not set for 12.288 MHz");
  pll_ext_a: assert property (
    state_q == S_CLK && strap_q |=> o_pll.bypass && !o_pll.pwr)
    else $error("pll not bypassed with strap high");
  clock_output_pin_off_a: assert property (
    state_q == S_CFG && $past(state_q) == S_CLKOFF |-> !o_clock_output_pin_en
      && $past(o_trim_apply))
    else $error("clock output still on at config step");
  nor_width_a: assert property (
    o_probe_req && o_probe.kind == PK_NOR |-> o_probe.wide16
      && o_probe.cs inside {[3'h2:3'h5]} && o_pclk_en[PCLK_EMIF])
    else $error("nor probe width or select wrong");
  nand_width_a: assert property (
    o_probe_req && o_probe.kind == PK_NAND |-> !o_probe.wide16)
    else $error("nand probe not 8-bit");
  probe_order_a: assert property (
    $rose(state_q == S_SPI) |-> $past(state_q) == S_NAND)
    else $error("spi probe out of order");
  fb_loop_a: assert property (
    state_q == S_USB |=> state_q == S_UART ##1 state_q == S_USB)
    else $error("fallback loop left");
  settle_jump_a: assert property (
    $rose(o_jump) |-> $past(tmr_exp) && !o_timer_run)
    else $error("jump before settle expiry");
  handoff_a: assert property (
    o_jump |-> o_pclk_en == 5'h00 && o_idle.periph && !o_idle.cpu)
    else $error("hand-off state wrong");
endmodule // rbs_boot_seq

/* dv/rbs_boot_dev_model.sv */
// Behavioural model of the external boot devices behind the sequencer.
`timescale 1ns/10ps
module rbs_boot_dev_model #(
  parameter logic [15:0] SIG = 16'h0001
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_probe_req,
  input  wire logic        i_load_req,
  input  wire logic [3:0]  i_match,
  input  wire logic [2:0]  i_lat,
  input  wire logic [23:0] i_entry_val,
  output logic             o_probe_done,
  output logic [15:0]      o_probe_sig,
  output logic             o_load_done,
  output logic [23:0]      o_entry
);
  int   n_q;
  int   wait_q;
  logic hold_q;

  // Outside the answer cycle the data lines toggle, so a design that
  // samples them late cannot be saved by a stale value.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      n_q          <= 0;
      wait_q       <= 0;
      hold_q       <= 1'b0;
      o_probe_done <= 1'b0;
      o_load_done  <= 1'b0;
      o_probe_sig  <= 16'h5a5a;
      o_entry      <= 24'h000000;
    end else begin
      o_probe_done <= 1'b0;
      o_load_done  <= 1'b0;
      o_probe_sig  <= ~o_probe_sig;
      o_entry      <= ~o_entry;
      // The answer is one pulse; the sequencer swaps a probe request for a
      // load request in the same edge, so the hold lasts one cycle only.
      if (hold_q || (!i_probe_req && !i_load_req)) begin
        hold_q <= 1'b0;
        wait_q <= 0;
      end else if (wait_q < i_lat) begin
        wait_q <= wait_q + 1;
      end else begin
        hold_q <= 1'b1;
        if (i_probe_req) begin
          o_probe_done <= 1'b1;
          // Only the selected device holds a valid two-byte signature.
          o_probe_sig  <= (n_q == i_match && i_match < 4'hb)
                          ? SIG : ~SIG;
          n_q          <= n_q + 1;
        end else begin
          o_load_done <= 1'b1;
          o_entry     <= i_entry_val;
        end
      end
    end
  end
endmodule // rbs_boot_dev_model

/* dv/tb.sv */
// Self-checking bench for the reset boot sequencer.
`timescale 1ns/10ps
module tb;
  import rbs_pkg::*;
  localparam int          SETTLE = 20;
  localparam logic [15:0] SIG    = 16'ha55a;
  typedef struct packed {
    logic       strap;
    logic       cfg;
    logic [3:0] match;
    logic [2:0] lat;
    rbs_kind_t  kind;
  } rbs_row_t;
  logic        clk, rst_n, clk_sel, has_cfg, cfg_done, p_done, l_done;
  logic        rom_map, slow, ck_en, trim, cfg_req, p_req, l_req;
  logic        fb, t_run, jump, ld_seen, saw_uart, saw_usb;
  logic [15:0] p_sig;
  logic [23:0] ent_in, ent_v, vec, ent_o;
  logic [3:0]  match;
  logic [2:0]  lat;
  logic [4:0]  pclk;
  rbs_idle_t   idle;
  rbs_pll_t    pll;
  rbs_probe_t  prb;
  rbs_kind_t   src;
  int          err_count, total_checks, n_probe, n_trim, n_cfg, settle, t;
  rbs_row_t    rows [9];

  rbs_boot_seq #(.BOOT_SIG(SIG), .SETTLE_CYC(SETTLE)) i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_clk_sel(clk_sel),
    .i_img_has_cfg(has_cfg), .i_cfg_done(cfg_done), .i_probe_done(p_done),
    .i_probe_sig(p_sig), .i_load_done(l_done), .i_entry(ent_in),
    .o_fetch_vec(vec), .o_rom_map(rom_map), .o_clock_output_pin_slow(slow),
    .o_clock_output_pin_en(ck_en), .o_idle(idle), .o_pll(pll), .o_trim_apply(trim),
    .o_cfg_req(cfg_req), .o_probe_req(p_req), .o_probe(prb),
    .o_load_req(l_req), .o_boot_src(src), .o_pclk_en(pclk),
    .o_fallback(fb), .o_timer_run(t_run), .o_jump(jump), .o_entry(ent_o));

  rbs_boot_dev_model #(.SIG(SIG)) i_dev (
    .i_clk(clk), .i_rst_n(rst_n), .i_probe_req(p_req), .i_load_req(l_req),
    .i_match(match), .i_lat(lat), .i_entry_val(ent_v),
    .o_probe_done(p_done), .o_probe_sig(p_sig), .o_load_done(l_done),
    .o_entry(ent_in));

  task automatic chk(string nm, logic [39:0] e, logic [39:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check_probe(int n);
    rbs_kind_t   k;
    logic [39:0] pll_e;
    k = n < 4 ? PK_NOR : n < 8 ? PK_NAND : n < 10 ? PK_SPI : PK_I2C;
    pll_e = {2'h2, PLL_VP_12M, PLL_VS_12M, 3'h3, PLL_VO_12M, MULT_12M};
    if (n > 10) return;
    chk("probe_kind", k, prb.kind);
    chk("pclk_q", n < 8 ? 5'h01 : n < 10 ? 5'h02 : 5'h04, pclk);
    if (n < 8) begin
      chk("probe_cs", 2 + n % 4, prb.cs);
      chk("probe_wide", n < 4, prb.wide16);
    end else if (n < 10) begin
      chk("spi_cs", 0, prb.cs);
      chk("spi_mode", n - 3, prb.bus_mode);
      chk("spi_rate", 10'h1f4, prb.rate_khz);
    end else begin
      chk("i2c_addr", 7'h50, prb.i2c_addr);
      chk("i2c_rate", 10'h190, prb.rate_khz);
    end
    if (n == 0) begin
      chk("trim_once", 1, n_trim);
      chk("cfg_applied", has_cfg, n_cfg > 0);
      chk("clock_output_pin_slow", 1, slow);
      chk("clock_output_pin_off", 0, ck_en);
      chk("idle_early", 5'h0e, idle);
      if (clk_sel) chk("pll_bypass", 1, pll.bypass);
      else chk("pll_12m", pll_e, pll);
    end
  endtask

  // Applied config entries leave the clock and the first timer alone.
  always @(posedge clk) cfg_done <= cfg_req && !cfg_done;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {n_probe, n_trim, n_cfg, settle} = '0;
      {ld_seen, saw_uart, saw_usb} = '0;
    end else begin
      n_trim += trim;
      n_cfg += cfg_req;
      saw_uart |= pclk[3];
      // USB is only polled for an image; its clock enable pclk[4] comes on while it is polled.
      saw_usb |= pclk[4];
      if (cfg_req && !has_cfg) chk("cfg_unasked", 0, 1);
      if (p_req && p_done) begin
        check_probe(n_probe);
        n_probe++;
      end
      if (ld_seen && !jump) settle++;
      if (ld_seen && !jump && settle == SETTLE / 2)
        chk("timer_run", 1, t_run);
      if (l_req && l_done) ld_seen = 1'b1;
    end
  end

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("fetch_vec", 24'hffff00, vec);
    chk("rom_map", 0, rom_map);
    chk("pclk_reset", 0, pclk);
    chk("jump_reset", 0, jump);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("boot_bypass", 1, pll.bypass);
  endtask

  task automatic wait_done(int lim);
    for (t = 0; t < lim && !(jump || fb); t++) begin
      @(posedge clk);
      #1;
    end
    chk("boot_end", 1, jump || fb);
  endtask

  task automatic run_row(rbs_row_t r);
    @(posedge clk);
    // The strap only moves while the device is held in reset.
    rst_n   <= 1'b0;
    clk_sel <= r.strap;
    has_cfg <= r.cfg;
    match   <= r.match;
    lat     <= r.lat;
    ent_v   <= {12'h010, 8'h00, r.match};
    do_reset();
    wait_done(3000);
    if (r.kind == PK_NONE) begin
      repeat (200) @(posedge clk);
      #1;
      chk("fallback", 1, fb);
      chk("fb_mult", r.strap ? 11'h003 : 11'h465, pll.mult);
      chk("all_tried", 1, n_probe >= 11);
      chk("uart_usb_loop", 2'h3, {saw_uart, saw_usb});
      chk("no_jump", 0, jump);
    end else begin
      chk("src", r.kind, src);
      chk("probes_used", r.match + 1, n_probe);
      chk("entry", ent_v, ent_o);
      chk("pclk_off", 0, pclk);
      chk("idle_handoff", 5'h0f, idle);
      chk("settle_min", 1, settle >= SETTLE);
      chk("settle_max", 1, settle <= SETTLE + 6);
      chk("no_fallback", 0, fb);
    end
  endtask

  initial begin
    clk = 1'b0;
    // With the strap high this clock stands for the board's reference input.
    forever #2.5 clk = ~clk;
  end

  initial begin
    {rst_n, clk_sel, has_cfg, match, lat, ent_v} = '0;
    {err_count, total_checks} = '0;
    rows = '{'{1'b0, 1'b0, 4'h0, 3'h0, PK_NOR},
             '{1'b1, 1'b1, 4'h3, 3'h3, PK_NOR},
             '{1'b0, 1'b0, 4'h4, 3'h1, PK_NAND},
             '{1'b1, 1'b1, 4'h7, 3'h0, PK_NAND},
             '{1'b0, 1'b1, 4'h8, 3'h4, PK_SPI},
             '{1'b1, 1'b0, 4'h9, 3'h0, PK_SPI},
             '{1'b0, 1'b0, 4'ha, 3'h2, PK_I2C},
             '{1'b1, 1'b1, 4'hf, 3'h0, PK_NONE},
             '{1'b0, 1'b0, 4'hf, 3'h1, PK_NONE}};
    foreach (rows[i]) run_row(rows[i]);
    // A reset in mid-probe must restart from the first NOR select; only
    // the I2C device answers, so every probe has to run again.
    @(posedge clk);
    match <= 4'ha;
    do_reset();
    for (t = 0; t < 500 && n_probe < 3; t++) @(posedge clk);
    chk("probe_reach", 1, n_probe >= 3);
    do_reset();
    wait_done(3000);
    chk("restart_src", PK_I2C, src);
    chk("restart_count", 11, n_probe);
    // A reset during the settle wait must never let the jump through.
    do_reset();
    for (t = 0; t < 500 && !ld_seen; t++) @(posedge clk);
    chk("load_reach", 1, ld_seen);
    repeat (SETTLE / 2) @(posedge clk);
    do_reset();
    chk("settle_abort", 0, t_run);
    wait_done(3000);
    chk("settle_redo", 1, settle >= SETTLE);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule // tb
